/* File: src/irctt_timer.sv */
// infrared carrier transmit timer top
// What this block does
// - timer is ten bits: nine-bit down counter plus carrier-enable latch on top
// - counter decrements once every eight oscillator periods on machine cycle
// - counting stops at zero and a completion indication is raised
// - completion releases a cpu waiting in timer standby
// - reload right after completion continues counting, but carrier is held low and indicator high for one clock
// - interval is loaded value plus one, times eight periods
// - carrier reaches output while running only if the enable latch is one
// - carrier stops on the first tick after the counter reaches zero
// - carrier output held low whenever no carrier is generated
// - transmit indicator low while carrier is output, high otherwise
// - oscillator-stop standby waits until the run state ends, one tick after the counter reaches zero
// - run/stop bit in the control register starts and stops the timer
// - reset drives carrier low, indicator high, clears all ten bits
// - carrier runs free of the timer, so edge pulses may be truncated
`timescale 1ns/1ps
`default_nettype none
module irctt_timer
	import irctt_pkg::*;
(
	input  wire logic       SYS_CLK,
	input  wire logic       RSTN,
	input  wire logic       CE,
	input  wire logic       MACHINE_CYCLE,
	input  wire logic       TIMER_LOAD,
	input  wire logic [9:0] TIMER_LOAD_DATA,
	input  wire logic [9:0] CONTROL_REGISTER,
	input  wire logic       DUTY_THIRD,
	input  wire logic       HALT_REQ,
	input  wire logic       HALT_WAIT_TIMER,
	output logic            CARRIER_OUTPUT_PIN,
	output logic            TX_INDICATOR_N,
	output logic            TIMER_DONE,
	output logic            CPU_WAKE,
	output logic            CPU_HALTED,
	output logic            OSC_STOP,
	output logic [8:0]      COUNT_VALUE
);
	import irctt_pkg::*;

	// machine-cycle prescaler
	logic [2:0]   tick_q;
	logic [2:0]   tick_d;
	logic         tick;

	// timer register and run state
	logic [9:0]   tmr_q;
	logic [9:0]   tmr_d;
	irctt_state_t st_q;
	irctt_state_t st_d;
	logic         run_en;
	logic         cnt_zero;

	// pin drivers
	logic         car_pin_q;
	logic         car_pin_d;
	logic         sout_q;
	logic         sout_d;
	logic         active;
	logic         carrier;

	// standby control
	logic         halt_q;
	logic         halt_d;
	logic         osc_stop_q;
	logic         osc_stop_d;
	logic         wake_q;
	logic         wake_d;

	irctt_carrier_gen u_car (
		.SYS_CLK    (SYS_CLK),
		.RSTN       (RSTN),
		.CE         (CE),
		.sel_div12  (CONTROL_REGISTER[CTRL_MOD_BIT]),
		.duty_third (DUTY_THIRD),
		.carrier    (carrier)
	);

	// one tick per eight machine-cycle periods
	always_comb begin
		tick_d = tick_q;
		tick   = 1'b0;
		if (MACHINE_CYCLE) begin
			tick_d = tick_q + 3'h1;
			tick   = (tick_q == TICK_LAST);
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			tick_q <= 3'h0;
		end else if (CE) begin
			tick_q <= tick_d;
		end
	end

	// run bit and zero detect
	always_comb begin
		run_en   = CONTROL_REGISTER[CTRL_RUN_BIT];
		cnt_zero = (tmr_q[CNT_WIDTH-1:0] == CNT_ZERO);
	end

	// nine-bit down counter and carrier-enable latch
	always_comb begin
		tmr_d = tmr_q;
		if (TIMER_LOAD) begin
			tmr_d = TIMER_LOAD_DATA;
		end else if (st_q == IRCTT_RUN && run_en && tick && !cnt_zero) begin
			tmr_d[CNT_WIDTH-1:0] = tmr_q[CNT_WIDTH-1:0] - 9'h001;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			tmr_q <= TMR_RESET;
		end else if (CE) begin
			tmr_q <= tmr_d;
		end
	end

	// run state: stopping lasts one cycle and marks completion
	always_comb begin
		st_d = st_q;
		case (st_q)
			IRCTT_IDLE: begin
				if (run_en && !cnt_zero) begin
					st_d = IRCTT_RUN;
				end
			end
			IRCTT_RUN: begin
				if (!run_en) begin
					st_d = IRCTT_IDLE;
				end else if (tick && cnt_zero) begin
					st_d = IRCTT_STOPPING;
				end
			end
			IRCTT_STOPPING: begin
				st_d = IRCTT_IDLE;
			end
			default: begin
				st_d = IRCTT_IDLE;
			end
		endcase
		// reload in the stopping cycle keeps the burst going
		if (TIMER_LOAD && run_en) begin
			st_d = IRCTT_RUN;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			st_q <= IRCTT_IDLE;
		end else if (CE) begin
			st_q <= st_d;
		end
	end

	// carrier gating and transmit indicator
	always_comb begin
		active    = (st_q == IRCTT_RUN);
		car_pin_d = 1'b0;
		sout_d    = 1'b1;
		if (active && tmr_q[CARRIER_EN_BIT]) begin
			car_pin_d = carrier;
			sout_d    = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			car_pin_q <= 1'b0;
			sout_q    <= 1'b1;
		end else if (CE) begin
			car_pin_q <= car_pin_d;
			sout_q    <= sout_d;
		end
	end

	// standby: wake, halt and oscillator stop
	always_comb begin
		wake_d = (st_q == IRCTT_STOPPING) && HALT_WAIT_TIMER;
		halt_d = halt_q;
		if (HALT_REQ) begin
			halt_d = 1'b1;
		end else if (wake_d) begin
			halt_d = 1'b0;
		end
		// oscillator stop waits for the count to finish
		osc_stop_d = osc_stop_q;
		if (halt_q && CONTROL_REGISTER[CTRL_OSC_BIT] && st_q != IRCTT_RUN && st_d != IRCTT_RUN) begin
			osc_stop_d = 1'b1;
		end else if (!halt_q) begin
			osc_stop_d = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			wake_q     <= 1'b0;
			halt_q     <= 1'b0;
			osc_stop_q <= 1'b0;
		end else if (CE) begin
			wake_q     <= wake_d;
			halt_q     <= halt_d;
			osc_stop_q <= osc_stop_d;
		end
	end

	assign CARRIER_OUTPUT_PIN = car_pin_q;
	assign TX_INDICATOR_N     = sout_q;
	assign TIMER_DONE         = (st_q != IRCTT_RUN);
	assign CPU_WAKE           = wake_q;
	assign CPU_HALTED         = halt_q;
	assign OSC_STOP           = osc_stop_q;
	assign COUNT_VALUE        = tmr_q[CNT_WIDTH-1:0];
endmodule
`default_nettype wire

/* File: src/irctt_pkg.sv */
// constants for the infrared carrier transmit timer
package irctt_pkg;
	localparam int          TMR_WIDTH       = 10;
	localparam int          CNT_WIDTH       = 9;
	localparam int          CARRIER_EN_BIT  = 9;
	localparam logic [9:0]  TMR_RESET       = 10'h000;
	localparam logic [8:0]  CNT_ZERO        = 9'h000;
	localparam int          TICK_PERIOD     = 8;
	localparam logic [2:0]  TICK_LAST       = 3'h7;
	localparam logic [3:0]  DIV8_LAST       = 4'h7;
	localparam logic [3:0]  DIV12_LAST      = 4'hB;
	localparam logic [3:0]  DIV8_HIGH       = 4'h4;
	localparam logic [3:0]  DIV12_HIGH_HALF = 4'h6;
	localparam logic [3:0]  DIV12_HIGH_THRD = 4'h4;
	localparam int          CTRL_MOD_BIT    = 3;
	localparam int          CTRL_RUN_BIT    = 2;
	localparam int          CTRL_OSC_BIT    = 6;
	typedef enum logic [1:0] {IRCTT_IDLE, IRCTT_RUN, IRCTT_STOPPING} irctt_state_t;
endpackage

/* File: src/irctt_carrier_gen.sv */
// free-running carrier divider, fosc/8 or fosc/12
`timescale 1ns/1ps
`default_nettype none
module irctt_carrier_gen
	import irctt_pkg::*;
(
	input  wire logic SYS_CLK,
	input  wire logic RSTN,
	input  wire logic CE,
	input  wire logic sel_div12,
	input  wire logic duty_third,
	output logic      carrier
);
	logic [3:0] div_q;
	logic [3:0] div_d;
	logic       car_q;
	logic       car_d;
	logic [3:0] last;
	logic [3:0] high;

	always_comb begin
		last  = sel_div12 ? DIV12_LAST : DIV8_LAST;
		high  = sel_div12 ? (duty_third ? DIV12_HIGH_THRD : DIV12_HIGH_HALF) : DIV8_HIGH;
		div_d = (div_q >= last) ? 4'h0 : div_q + 4'h1;
		car_d = (div_d < high);
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			div_q <= 4'h0;
			car_q <= 1'b0;
		end else if (CE) begin
			div_q <= div_d;
			car_q <= car_d;
		end
	end

	assign carrier = car_q;
endmodule
`default_nettype wire

/* File: sim/irctt_timer_asserts.sv */
// checker for the carrier transmit timer
`timescale 1ns/1ps
`default_nettype none
module irctt_timer_asserts
	import irctt_pkg::*;
(
	input wire logic       SYS_CLK,
	input wire logic       RSTN,
	input wire logic       TIMER_LOAD,
	input wire logic [9:0] TIMER_LOAD_DATA,
	input wire logic [9:0] CONTROL_REGISTER,
	input wire logic       CARRIER_OUTPUT_PIN,
	input wire logic       TX_INDICATOR_N,
	input wire logic       TIMER_DONE,
	input wire logic       CPU_WAKE,
	input wire logic [8:0] COUNT_VALUE
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);
	load_cnt_a: assert property (TIMER_LOAD && CONTROL_REGISTER[CTRL_RUN_BIT] |=>
		COUNT_VALUE == $past(TIMER_LOAD_DATA[8:0]) && !TIMER_DONE) else $error("load lost");
	dec_step_a: assert property ($changed(COUNT_VALUE) && !$past(TIMER_LOAD) |->
		COUNT_VALUE == $past(COUNT_VALUE) - 9'h001) else $error("bad step");
	zero_hold_a: assert property (TIMER_DONE && COUNT_VALUE == CNT_ZERO && !TIMER_LOAD |=>
		COUNT_VALUE == CNT_ZERO) else $error("count left zero");
	wake_pulse_a: assert property (CPU_WAKE |=> !CPU_WAKE) else $error("wake too long");
	wake_cause_a: assert property (CPU_WAKE |-> $past(TIMER_DONE)) else $error("early wake");
	idle_low_a: assert property (TIMER_DONE && $past(TIMER_DONE) |->
		!CARRIER_OUTPUT_PIN) else $error("carrier idle high");
	ind_idle_a: assert property (TIMER_DONE && $past(TIMER_DONE) |->
		TX_INDICATOR_N) else $error("indicator idle low");
	car_ind_a: assert property (CARRIER_OUTPUT_PIN |-> !TX_INDICATOR_N) else $error("indicator high");
endmodule
bind irctt_timer irctt_timer_asserts i_chk(.*);
`default_nettype wire

/* File: sim/irctt_led_model.sv */
// infrared led driver counting carrier pulses
`timescale 1ns/1ps
`default_nettype none
module irctt_led_model (
	input  wire logic sys_clk,
	input  wire logic led_in,
	output int        pulses
);
	logic last = 1'h0;
	initial pulses = 0;
	always @(posedge sys_clk) begin
		if (led_in === 1'h1 && last !== 1'h1) pulses <= pulses + 1;
		last <= led_in;
	end
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// bench for the carrier transmit timer
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic       clk = 0, rstn = 0, ld = 0, hr = 0, hw = 1, car, txn, done, wake, halted, osc;
	logic [9:0] ldd = 0, cr = 0;
	logic [8:0] cnt;
	int         error_cnt = 0, n_tests = 0, p, c, q;
	always #2.5 clk = ~clk;
	irctt_timer i_dut(.SYS_CLK(clk), .RSTN(rstn), .CE(1'h1), .MACHINE_CYCLE(1'h1), .TIMER_LOAD(ld),
		.TIMER_LOAD_DATA(ldd), .CONTROL_REGISTER(cr), .DUTY_THIRD(1'h0), .HALT_REQ(hr), .HALT_WAIT_TIMER(hw),
		.CARRIER_OUTPUT_PIN(car), .TX_INDICATOR_N(txn), .TIMER_DONE(done), .CPU_WAKE(wake),
		.CPU_HALTED(halted), .OSC_STOP(osc), .COUNT_VALUE(cnt));
	irctt_led_model i_led(.sys_clk(clk), .led_in(car), .pulses(p));
	task automatic chk(input logic ok);
		n_tests++;
		if (ok !== 1'h1) begin
			error_cnt++;
			$display("wrong value at %0t on an output", $time);
		end
	endtask
	task automatic burst(input logic [9:0] d, r, input int lo, hi);
		q = p;
		c = 0;
		@(posedge clk);
		cr <= r;
		ldd <= d;
		ld <= 1'h1;
		hr <= 1'h1;
		@(posedge clk);
		ld <= 1'h0;
		hr <= 1'h0;
		while (wake !== 1'h1 && c < 300) begin
			@(negedge clk);
			c++;
			if (c == 9) chk(txn === !d[9]);
		end
		chk(c > 8 * d[8:0] && c < 8 * d[8:0] + 12);
		chk(p - q >= lo && p - q <= hi);
		@(negedge clk);
		chk(car === 1'h0 && txn === 1'h1);
		$display("burst %h over", d);
	endtask
	task t_div8;
		burst(10'h20B, 10'h004, 10, 13);
	endtask
	task t_div12;
		burst(10'h20B, 10'h00C, 7, 9);
	endtask
	task t_silent;
		burst(10'h00B, 10'h004, 0, 0);
	endtask
	task t_stop;
		@(posedge clk);
		cr <= 10'h000;
		ldd <= 10'h205;
		ld <= 1'h1;
		@(posedge clk);
		ld <= 1'h0;
		repeat (20) @(negedge clk);
		chk(done === 1'h1 && car === 1'h0);
		$display("stop over");
	endtask
	task t_halt;
		@(posedge clk);
		cr <= 10'h044;
		ldd <= 10'h003;
		ld <= 1'h1;
		hr <= 1'h1;
		hw <= 1'h0;
		@(posedge clk);
		ld <= 1'h0;
		hr <= 1'h0;
		repeat (4) @(negedge clk);
		chk(halted === 1'h1 && osc === 1'h0 && done === 1'h0);
		repeat (45) @(negedge clk);
		chk(osc === 1'h1 && halted === 1'h1 && wake === 1'h0);
		$display("halt over");
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		@(negedge clk);
		chk(car === 1'h0 && txn === 1'h1 && done === 1'h1 && cnt === 9'h000);
		repeat (16) @(posedge clk);
		rstn <= 1'h1;
		t_div8;
		t_div12;
		t_silent;
		t_stop;
		t_halt;
		stop_test;
	end
	initial begin
		#10000;
		error_cnt++;
		stop_test;
	end
endmodule
`default_nettype wire
